// file: rtl/drive_ctrl_pkg.sv
// package: constants and types for the drive control state machine
package drive_ctrl_pkg;

  // ==========================================
  // control word values
  localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CW_ENABLE = 16'h000F;
  localparam logic [15:0] CW_DISABLE = 16'h0000;
  localparam logic [15:0] CW_QUICK_STOP = 16'h0002;
  localparam logic [15:0] CW_FAULT_RESET = 16'h0080;

  // ==========================================
  // status word values
  localparam logic [15:0] SW_INIT = 16'h0000;
  localparam logic [15:0] SW_FAULTLESS = 16'h0250;
  localparam logic [15:0] SW_READY = 16'h0231;
  localparam logic [15:0] SW_WAIT_EN = 16'h0233;
  localparam logic [15:0] SW_RUNNING = 16'h0237;
  localparam logic [15:0] SW_QSTOP = 16'h0217;
  localparam logic [15:0] SW_FAULT_STOP = 16'h021F;
  localparam logic [15:0] SW_FAULT = 16'h0218;
  localparam logic [15:0] SW_RESET = 16'h0000;
  // status bit raised when homing completes
  localparam int SW_HOMED_BIT = 12;

  // ==========================================
  // supported modes map
  localparam int PROFILE_POSITION_MODE_BIT = 0;
  localparam int PROFILE_VELOCITY_MODE_BIT = 2;
  localparam int PROFILE_TORQUE_MODE_BIT = 3;
  localparam int HOMING_MODE_BIT = 5;
  localparam int CYCLIC_SYNC_POSITION_MODE_BIT = 7;
  localparam int CYCLIC_SYNC_VELOCITY_MODE_BIT = 8;
  localparam int CYCLIC_SYNC_TORQUE_MODE_BIT = 9;
  localparam logic [31:0] SUPPORTED_MODES_MAP = 32'h000003AD;

  // ==========================================
  // timing: init wait and quick stop dwell before automatic fall to faultless
  localparam int QSTOP_TIME_US = 10;
  localparam int CLK_MHZ = 40;
  localparam int QSTOP_CYCLES = QSTOP_TIME_US * CLK_MHZ;
  localparam int INIT_CYCLES = 16;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_FAULTLESS,
    ST_READY,
    ST_WAIT_EN,
    ST_RUNNING,
    ST_QSTOP,
    ST_FAULT_STOP,
    ST_FAULT
  } drive_state_e;

  typedef struct packed {
    logic [31:0] position;
    logic [31:0] velocity;
  } feedback_s;

endpackage

// file: rtl/pin_sync.sv
// module: two-stage synchroniser for asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// file: rtl/cycle_timer.sv
// module: down counter that reports expiry after a loaded count
`timescale 1ns/100ps
module cycle_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic expired
);
  logic [WIDTH-1:0] remain;
  logic running;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      remain <= '0;
      running <= 1'b0;
    end
    else if (load)
    begin
      remain <= count;
      running <= 1'b1;
    end
    else if (running && remain != '0)
      remain <= remain - 1'b1;
  end

  assign expired = running && !load && (remain == '0);
endmodule

// file: rtl/drive_control_state_machine.sv
// module: drive profile control state machine answering control words with status words
`timescale 1ns/100ps
module drive_control_state_machine
  import drive_ctrl_pkg::*;
#(
  parameter int TIMER_WIDTH = 16,
  parameter int QSTOP_COUNT = QSTOP_CYCLES,
  parameter int INIT_COUNT = INIT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] control_word,
  input wire logic control_valid,
  input wire logic fault_pin,
  input wire logic alarm_resolved_pin,
  input wire logic homing_start,
  input wire logic homing_done_pin,
  input wire feedback_s actual_in,
  output logic [15:0] status_word,
  output logic [31:0] supported_modes_map,
  output logic axis_enable,
  output logic brake_engaged,
  output feedback_s actual_out,
  output drive_state_e drive_state
);

  // ==========================================
  // pin synchronisation
  logic [2:0] pins_sync;
  logic fault_s;
  logic alarm_ok_s;
  logic homed_s;

  pin_sync #(.WIDTH(3)) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({fault_pin, alarm_resolved_pin, homing_done_pin}),
    .sync_out(pins_sync)
  );

  assign fault_s = pins_sync[2];
  assign alarm_ok_s = pins_sync[1];
  assign homed_s = pins_sync[0];

  // ==========================================
  // one shared timer for automatic transitions
  logic timer_load;
  logic [TIMER_WIDTH-1:0] timer_count;
  logic timer_expired;

  cycle_timer #(.WIDTH(TIMER_WIDTH)) u_timer (
    .clk(clk),
    .resetn(resetn),
    .load(timer_load),
    .count(timer_count),
    .expired(timer_expired)
  );

  // ==========================================
  // command decode
  // a word must match exactly; a known code with stray bits set names
  // no transition, which is safer than masking on a motor enable path
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_SHUTDOWN,
    CMD_SWITCH_ON,
    CMD_ENABLE,
    CMD_DISABLE,
    CMD_QUICK_STOP,
    CMD_FAULT_RESET
  } command_e;

  command_e command;

  always_comb
  begin
    command = CMD_NONE;
    if (control_valid)
    begin
      case (control_word)
        CW_SHUTDOWN: command = CMD_SHUTDOWN;
        CW_SWITCH_ON: command = CMD_SWITCH_ON;
        CW_ENABLE: command = CMD_ENABLE;
        CW_DISABLE: command = CMD_DISABLE;
        CW_QUICK_STOP: command = CMD_QUICK_STOP;
        CW_FAULT_RESET: command = CMD_FAULT_RESET;
        default: command = CMD_NONE;
      endcase
    end
  end

  // ==========================================
  // state transitions
  drive_state_e state;
  drive_state_e next_state;
  logic init_started;

  function automatic logic [15:0] status_of(input drive_state_e s);
    unique case (s)
      ST_INIT: status_of = SW_INIT;
      ST_FAULTLESS: status_of = SW_FAULTLESS;
      ST_READY: status_of = SW_READY;
      ST_WAIT_EN: status_of = SW_WAIT_EN;
      ST_RUNNING: status_of = SW_RUNNING;
      ST_QSTOP: status_of = SW_QSTOP;
      ST_FAULT_STOP: status_of = SW_FAULT_STOP;
      ST_FAULT: status_of = SW_FAULT;
    endcase
  endfunction

  always_comb
  begin
    next_state = state;
    if (fault_s && state != ST_FAULT_STOP && state != ST_FAULT)
      next_state = ST_FAULT_STOP;
    else
    begin
      unique case (state)
        ST_INIT:
          if (init_started && timer_expired)
            next_state = ST_FAULTLESS;
        ST_FAULTLESS:
          if (command == CMD_SHUTDOWN)
            next_state = ST_READY;
        ST_READY:
          if (command == CMD_SWITCH_ON)
            next_state = ST_WAIT_EN;
          else if (command == CMD_DISABLE)
            next_state = ST_FAULTLESS;
        ST_WAIT_EN:
          if (command == CMD_ENABLE)
            next_state = ST_RUNNING;
          else if (command == CMD_SHUTDOWN)
            next_state = ST_READY;
          else if (command == CMD_DISABLE)
            next_state = ST_FAULTLESS;
        ST_RUNNING:
          if (command == CMD_SWITCH_ON)
            next_state = ST_WAIT_EN;
          else if (command == CMD_SHUTDOWN)
            next_state = ST_READY;
          else if (command == CMD_DISABLE)
            next_state = ST_FAULTLESS;
          else if (command == CMD_QUICK_STOP)
            next_state = ST_QSTOP;
        ST_QSTOP:
          if (command == CMD_ENABLE)
            next_state = ST_RUNNING;
          else if (timer_expired)
            next_state = ST_FAULTLESS;
        ST_FAULT_STOP:
          if (alarm_ok_s)
            next_state = ST_FAULT;
        ST_FAULT:
          if (command == CMD_FAULT_RESET)
            next_state = ST_FAULTLESS;
      endcase
    end
    // anything else keeps the state
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state <= ST_INIT;
    else
      state <= next_state;
  end

  // timer loads on entry to init and quick stop
  always_ff @(posedge clk)
  begin
    if (!resetn)
      init_started <= 1'b0;
    else if (state == ST_INIT)
      init_started <= 1'b1;
    else
      init_started <= 1'b0;
  end

  always_comb
  begin
    timer_load = 1'b0;
    timer_count = '0;
    if (state == ST_INIT && !init_started)
    begin
      timer_load = 1'b1;
      timer_count = TIMER_WIDTH'(INIT_COUNT);
    end
    else if (next_state == ST_QSTOP && state != ST_QSTOP)
    begin
      timer_load = 1'b1;
      timer_count = TIMER_WIDTH'(QSTOP_COUNT);
    end
  end

  // ==========================================
  // homing: request latches, completion reported while enabled
  logic homing_req;
  logic homed;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      homing_req <= 1'b0;
      homed <= 1'b0;
    end
    else if (next_state != ST_RUNNING)
    begin
      homing_req <= 1'b0;
      homed <= homed && next_state != ST_INIT;
    end
    else if (homing_start)
    begin
      homing_req <= 1'b1;
      homed <= 1'b0;
    end
    else if (homing_req && homed_s)
    begin
      homing_req <= 1'b0;
      homed <= 1'b1;
    end
  end

  // ==========================================
  // outputs, all registered
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      status_word <= SW_RESET;
      axis_enable <= 1'b0;
      brake_engaged <= 1'b1;
      drive_state <= ST_INIT;
    end
    else
    begin
      status_word <= status_of(next_state);
      if (homed && next_state == ST_RUNNING)
        status_word[SW_HOMED_BIT] <= 1'b1;
      // only running drives the axis; the brake is released in running and quick stop
      axis_enable <= (next_state == ST_RUNNING);
      brake_engaged <= (next_state != ST_RUNNING && next_state != ST_QSTOP);
      drive_state <= next_state;
    end
  end

  // feedback sampled every cycle so the master can monitor motion
  always_ff @(posedge clk)
  begin
    if (!resetn)
      actual_out <= '0;
    else
      actual_out <= actual_in;
  end

  // ==========================================
  // supported modes map
  // each supported mode owns one bit; every other bit, reserved ones
  // included, reads zero and there is no write path at all
  function automatic logic mode_listed(input int pos);
    mode_listed = (pos == PROFILE_POSITION_MODE_BIT)
      || (pos == PROFILE_VELOCITY_MODE_BIT)
      || (pos == PROFILE_TORQUE_MODE_BIT)
      || (pos == HOMING_MODE_BIT)
      || (pos == CYCLIC_SYNC_POSITION_MODE_BIT)
      || (pos == CYCLIC_SYNC_VELOCITY_MODE_BIT)
      || (pos == CYCLIC_SYNC_TORQUE_MODE_BIT);
  endfunction

  logic [31:0] modes_built;

  for (genvar g = 0; g < 32; g++)
  begin : g_mode_bit
    assign modes_built[g] = mode_listed(g);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      supported_modes_map <= SUPPORTED_MODES_MAP;
    else
      supported_modes_map <= modes_built;
  end

endmodule

// file: testbench/drive_control_monitor.sv
// checker: control word to status word relations at the block's ports
`timescale 1ns/100ps
module drive_control_monitor
  import drive_ctrl_pkg::*;
#(
  parameter int QSTOP_COUNT = QSTOP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] control_word,
  input wire logic control_valid,
  input wire logic fault_pin,
  input wire logic [15:0] status_word,
  input wire logic [31:0] supported_modes_map,
  input wire logic axis_enable,
  input wire feedback_s actual_in,
  input wire feedback_s actual_out,
  input wire drive_state_e drive_state
);
  localparam int QB = QSTOP_COUNT + 2;
  logic [2:0] fault_hist;
  logic calm;
  logic [15:0] word;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // a fault overrides any word except fault reset in the fault state, and it takes three cycles to show
  always_ff @(posedge clk)
    fault_hist <= {fault_hist[1:0], fault_pin};
  assign calm = fault_hist == 3'h0 && !fault_pin;
  assign word = (calm && control_valid) ? control_word : 16'hFFFF;
  a_map_fixed: assert property (supported_modes_map == 32'h000003AD) else $error("map changed");
  a_enable_in_run: assert property (axis_enable |-> drive_state == ST_RUNNING) else $error("axis on");
  a_shutdown_ready:
    assert property (word == CW_SHUTDOWN && drive_state inside {ST_FAULTLESS, ST_WAIT_EN, ST_RUNNING}
      |=> status_word == SW_READY) else $error("no ready");
  a_switch_wait:
    assert property (word == CW_SWITCH_ON && drive_state inside {ST_READY, ST_RUNNING}
      |=> status_word == SW_WAIT_EN && !axis_enable) else $error("no wait");
  a_enable_run:
    assert property (word == CW_ENABLE && drive_state inside {ST_WAIT_EN, ST_QSTOP}
      |=> status_word == SW_RUNNING) else $error("no run");
  a_disable_idle:
    assert property (word == CW_DISABLE && drive_state inside {ST_READY, ST_WAIT_EN, ST_RUNNING}
      |=> status_word == SW_FAULTLESS) else $error("no faultless");
  a_quick_stop:
    assert property (word == CW_QUICK_STOP && drive_state == ST_RUNNING |=> status_word == SW_QSTOP) else $error("qs");
  a_qstop_ends:
    assert property (drive_state == ST_QSTOP |-> ##[1:QB] drive_state != ST_QSTOP) else $error("qs stuck");
  a_fault_clear:
    assert property (word == CW_FAULT_RESET && drive_state == ST_FAULT |=> status_word == SW_FAULTLESS) else $error("clr");
  a_state_hold:
    assert property (calm && !control_valid && drive_state inside {ST_FAULTLESS, ST_READY, ST_WAIT_EN}
      |=> $stable(drive_state)) else $error("state moved");
  a_fault_seen:
    assert property ((fault_pin && !control_valid)[*4] |-> status_word inside {SW_FAULT_STOP, SW_FAULT})
      else $error("fault missed");
  a_feedback_copy:
    assert property ($past(resetn) |-> actual_out == $past(actual_in)) else $error("feedback");
endmodule

bind drive_control_state_machine drive_control_monitor #(.QSTOP_COUNT(QSTOP_COUNT)) mon_inst (.clk(clk),
  .resetn(resetn), .control_word(control_word), .control_valid(control_valid), .fault_pin(fault_pin),
  .status_word(status_word), .supported_modes_map(supported_modes_map), .axis_enable(axis_enable),
  .actual_in(actual_in), .actual_out(actual_out), .drive_state(drive_state));

// file: testbench/bus_master.sv
// partner: fieldbus master that writes one control word per pulse
`timescale 1ns/100ps
module bus_master (
  input wire logic clk,
  output logic [15:0] control_word,
  output logic control_valid
);
  initial
  begin
    control_word = 16'h5A5A;
    control_valid = 1'b0;
  end
  // released word is inverted so a stale value never looks valid
  task automatic send(input logic [15:0] word, input int gap);
    repeat (gap + 1) @(negedge clk);
    control_word = word;
    control_valid = 1'b1;
    @(negedge clk);
    control_word = ~word;
    control_valid = 1'b0;
  endtask
endmodule

// file: testbench/tb_drive_control_state_machine.sv
// testbench: control word sequences checked against status words
`timescale 1ns/100ps
module tb_drive_control_state_machine
  import drive_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic fault_pin = 1'b0;
  logic alarm_resolved_pin = 1'b0;
  logic homing_start = 1'b0;
  logic homing_done_pin = 1'b0;
  feedback_s actual_in = '0;
  logic [15:0] control_word;
  logic control_valid;
  logic [15:0] status_word;
  logic [31:0] supported_modes_map;
  logic axis_enable;
  logic brake_engaged;
  feedback_s actual_out;
  drive_state_e drive_state;
  int miscompares = 0;
  int comparisons = 0;
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
  always #12.5 clk = ~clk;
  bus_master bus_master_inst (.clk(clk), .control_word(control_word), .control_valid(control_valid));
  drive_control_state_machine #(.QSTOP_COUNT(4), .INIT_COUNT(4)) drive_control_state_machine_inst (
    .clk(clk), .resetn(resetn), .control_word(control_word), .control_valid(control_valid),
    .fault_pin(fault_pin), .alarm_resolved_pin(alarm_resolved_pin), .homing_start(homing_start),
    .homing_done_pin(homing_done_pin), .actual_in(actual_in), .status_word(status_word),
    .supported_modes_map(supported_modes_map), .axis_enable(axis_enable), .brake_engaged(brake_engaged),
    .actual_out(actual_out), .drive_state(drive_state));
  task automatic step(input logic [15:0] word, input logic [15:0] exp);
    bus_master_inst.send(word, 0);
    `CHECK(status_word, exp)
  endtask
  task automatic wait_for(input logic [15:0] exp);
    int n;
    n = 0;
    while (status_word !== exp && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    `CHECK(status_word, exp)
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(negedge clk);
    `CHECK(status_word, SW_INIT)
    `CHECK(brake_engaged, 1'b1)
    `CHECK(supported_modes_map, 32'h000003AD)
    resetn = 1'b1;
    wait_for(SW_FAULTLESS);
    step(CW_ENABLE, SW_FAULTLESS);
    step(CW_SHUTDOWN, SW_READY);
    step(CW_DISABLE, SW_FAULTLESS);
    step(CW_SHUTDOWN, SW_READY);
    step(CW_SWITCH_ON, SW_WAIT_EN);
    step(CW_SHUTDOWN, SW_READY);
    step(CW_SWITCH_ON, SW_WAIT_EN);
    step(CW_DISABLE, SW_FAULTLESS);
    step(CW_SHUTDOWN, SW_READY);
    step(CW_SWITCH_ON, SW_WAIT_EN);
    step(CW_ENABLE, SW_RUNNING);
    `CHECK(axis_enable, 1'b1)
    `CHECK(brake_engaged, 1'b0)
    step(CW_FAULT_RESET, SW_RUNNING);
    step(CW_SWITCH_ON, SW_WAIT_EN);
    `CHECK(axis_enable, 1'b0)
    step(CW_ENABLE, SW_RUNNING);
    step(CW_SHUTDOWN, SW_READY);
    step(CW_SWITCH_ON, SW_WAIT_EN);
    step(CW_ENABLE, SW_RUNNING);
    step(CW_DISABLE, SW_FAULTLESS);
    $display("test sequence finished");
    step(CW_SHUTDOWN, SW_READY);
    step(CW_SWITCH_ON, SW_WAIT_EN);
    step(CW_ENABLE, SW_RUNNING);
    step(CW_QUICK_STOP, SW_QSTOP);
    step(CW_ENABLE, SW_RUNNING);
    step(CW_QUICK_STOP, SW_QSTOP);
    wait_for(SW_FAULTLESS);
    $display("test quick_stop finished");
    step(CW_SHUTDOWN, SW_READY);
    step(CW_SWITCH_ON, SW_WAIT_EN);
    step(CW_ENABLE, SW_RUNNING);
    homing_start = 1'b1;
    @(negedge clk);
    homing_start = 1'b0;
    homing_done_pin = 1'b1;
    wait_for(SW_RUNNING | 16'h1000);
    actual_in = {32'h12345678, 32'h9ABCDEF0};
    repeat (2) @(negedge clk);
    `CHECK(actual_out, actual_in)
    $display("test homing finished");
    fault_pin = 1'b1;
    wait_for(SW_FAULT_STOP);
    `CHECK(axis_enable, 1'b0)
    `CHECK(brake_engaged, 1'b1)
    step(CW_FAULT_RESET, SW_FAULT_STOP);
    fault_pin = 1'b0;
    alarm_resolved_pin = 1'b1;
    wait_for(SW_FAULT);
    step(CW_FAULT_RESET, SW_FAULTLESS);
    alarm_resolved_pin = 1'b0;
    resetn = 1'b0;
    fault_pin = 1'b1;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    wait_for(SW_FAULT_STOP);
    $display("test faults finished");
    complete_run();
  end
endmodule
